// ==== src/pmgr_top.sv ====
// Power manager: activity timers, interrupts, throttle, planes, suspend
//
// Implementation choices: the register offsets and the APB register port.
`include "pmgr_cfg.svh"

module pmgr_top #(
    parameter int TW          = 16,
    parameter int TICK_CYCLES = `PMGR_TICK_CYCLES
) (
    // Clock and reset
    input  wire logic                     clk_in,
    input  wire logic                     reset_n_in,
    // APB slave
    input  wire logic                     psel_in,
    input  wire logic                     penable_in,
    input  wire logic                     pwrite_in,
    input  wire logic [7:0]               paddr_in,
    input  wire logic [31:0]              pwdata_in,
    output logic      [31:0]              prdata_out,
    output logic                          pready_out,
    output logic                          pslverr_out,
    // Activity detectors
    input  wire logic                     sys_activity_in,
    input  wire logic                     hk_activity_in,
    input  wire logic                     periph_activity_in,
    // Processor core
    input  wire logic                     core_idle_in,
    output logic                          core_stop_req_out,
    output logic                          clock_stop_out,
    // Power outputs
    output logic                          system_management_irq_out,
    output logic                          suspend_throttle_out,
    output logic [`PMGR_PLANE_W-1:0]      power_plane_off_out,
    output logic                          hk_service_out,
    output logic [1:0]                    power_state_out
);

    localparam int NT = 5;
    localparam int PW = $clog2(TICK_CYCLES);

    // ------------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------------
    function automatic logic is_mapped(input logic [7:0] a);
        is_mapped = (a[1:0] == 2'b00) && (a <= `PMGR_OFF_STATE);
    endfunction

    pmgr_pkg::pmgr_apb_req_t req;
    pmgr_pkg::pmgr_act_t     act;

    assign req = '{psel: psel_in, penable: penable_in, pwrite: pwrite_in,
                   paddr: paddr_in, pwdata: pwdata_in};
    assign act = '{sys: sys_activity_in, hk: hk_activity_in,
                   periph: periph_activity_in};

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    logic                      en_q,      en_d;
    pmgr_pkg::pmgr_pstate_t    pstate_q,  pstate_d;
    logic [TW-1:0]             tval_q [NT];
    logic [TW-1:0]             tval_d [NT];
    logic [15:0]               thr_q,     thr_d;
    logic [`PMGR_PLANE_W-1:0]  plane_q,   plane_d;
    logic [`PMGR_EV_W-1:0]     stat_q,    stat_d;
    logic [`PMGR_EV_W-1:0]     irqen_q,   irqen_d;
    logic                      irq_q,     irq_d;
    logic [31:0]               rdata_q,   rdata_d;
    logic                      ready_q,   ready_d;
    logic                      err_q,     err_d;
    pmgr_pkg::pmgr_seq_t       seq_q,     seq_d;
    logic                      stopreq_q, stopreq_d;
    logic                      clkstop_q, clkstop_d;
    logic                      hksvc_q,   hksvc_d;
    logic [PW-1:0]             pre_q,     pre_d;
    logic                      tick_q,    tick_d;

    logic                      access;
    logic                      wr;
    logic [`PMGR_EV_W-1:0]     events;
    logic [`PMGR_EV_W-1:0]     clr;
    logic [NT-1:0]             reload;
    logic [NT-1:0]             expire;
    logic [NT-1:0]             active;
    logic                      powered_down;
    logic                      hk_window;
    logic [3:0]                duty;
    logic                      throttle;

    assign access       = req.psel && req.penable && !ready_q;
    assign wr           = access && req.pwrite && is_mapped(req.paddr);
    assign powered_down = (pstate_q != pmgr_pkg::PS_ON);
    assign hk_window    = (pstate_q == pmgr_pkg::PS_DOZE) ||
                          (pstate_q == pmgr_pkg::PS_STBY);

    // ------------------------------------------------------------------
    // Tick prescaler
    // ------------------------------------------------------------------
    always_comb begin
        tick_d = 1'b0;
        pre_d  = pre_q + PW'(1);
        if (pre_q == PW'(TICK_CYCLES - 1)) begin
            pre_d  = '0;
            tick_d = 1'b1;
        end
    end

    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            pre_q  <= '0;
            tick_q <= 1'b0;
        end else begin
            pre_q  <= pre_d;
            tick_q <= tick_d;
        end
    end

    // ------------------------------------------------------------------
    // Inactivity timers: doze, standby, suspend, house-keeping, peripheral
    // ------------------------------------------------------------------
    always_comb begin
        reload[0] = !en_q || act.sys;
        reload[1] = !en_q || act.sys;
        reload[2] = !en_q || act.sys;
        reload[3] = act.hk && hk_window;
        reload[4] = !en_q || act.periph;
    end

    for (genvar i = 0; i < NT; i++) begin : g_timer
        pmgr_timer #(
            .W          (TW)
        ) u_timer (
            .clk_in     (clk_in),
            .reset_n_in (reset_n_in),
            .tick_in    (tick_q && !clkstop_q),
            .reload_in  (reload[i]),
            .value_in   (tval_q[i]),
            .expire_out (expire[i]),
            .active_out (active[i])
        );
    end

    // ------------------------------------------------------------------
    // Events
    // ------------------------------------------------------------------
    always_comb begin
        events = '0;
        events[`PMGR_EV_DOZE]   = expire[0];
        events[`PMGR_EV_STBY]   = expire[1];
        events[`PMGR_EV_SUSPEND_THROTTLE_OUT]   = expire[2];
        events[`PMGR_EV_WAKE]   = act.sys && powered_down;
        events[`PMGR_EV_PERIPH] = expire[4];
        events[`PMGR_EV_HK]     = expire[3];
        clr = '0;
        if (wr && (req.paddr == `PMGR_OFF_CLEAR)) begin
            clr = req.pwdata[`PMGR_EV_W-1:0];
        end
    end

    // ------------------------------------------------------------------
    // Register file and bus answer
    // ------------------------------------------------------------------
    always_comb begin
        en_d     = en_q;
        pstate_d = pstate_q;
        tval_d   = tval_q;
        thr_d    = thr_q;
        plane_d  = plane_q;
        irqen_d  = irqen_q;
        rdata_d  = rdata_q;
        ready_d  = access;
        err_d    = access && !is_mapped(req.paddr);
        stat_d   = (stat_q & ~clr) | events;
        irq_d    = |(stat_d & irqen_d);
        if (wr) begin
            unique case (req.paddr)
                `PMGR_OFF_CTRL: begin
                    en_d     = req.pwdata[`PMGR_CTRL_EN_BIT];
                    pstate_d = pmgr_pkg::pmgr_pstate_t'(
                        req.pwdata[`PMGR_CTRL_ST_MSB:`PMGR_CTRL_ST_LSB]);
                end
                `PMGR_OFF_DOZE_T:   tval_d[0] = req.pwdata[TW-1:0];
                `PMGR_OFF_STBY_T:   tval_d[1] = req.pwdata[TW-1:0];
                `PMGR_OFF_SUSPEND_THROTTLE_OUT_T:   tval_d[2] = req.pwdata[TW-1:0];
                `PMGR_OFF_HK_T:     tval_d[3] = req.pwdata[TW-1:0];
                `PMGR_OFF_PERIPH_T: tval_d[4] = req.pwdata[TW-1:0];
                `PMGR_OFF_THROTTLE: thr_d     = req.pwdata[15:0];
                `PMGR_OFF_PLANE:    plane_d   = req.pwdata[`PMGR_PLANE_W-1:0];
                `PMGR_OFF_IRQ_EN:   irqen_d   = req.pwdata[`PMGR_EV_W-1:0];
                default: begin
                end
            endcase
        end
        if ((seq_q == pmgr_pkg::SEQ_STOPPED) && act.sys) begin
            pstate_d = pmgr_pkg::PS_ON;
        end
        if (access && !req.pwrite) begin
            rdata_d = '0;
            unique case (req.paddr)
                `PMGR_OFF_CTRL:     rdata_d = {29'h0000000, pstate_q, en_q};
                `PMGR_OFF_DOZE_T:   rdata_d = 32'(tval_q[0]);
                `PMGR_OFF_STBY_T:   rdata_d = 32'(tval_q[1]);
                `PMGR_OFF_SUSPEND_THROTTLE_OUT_T:   rdata_d = 32'(tval_q[2]);
                `PMGR_OFF_HK_T:     rdata_d = 32'(tval_q[3]);
                `PMGR_OFF_PERIPH_T: rdata_d = 32'(tval_q[4]);
                `PMGR_OFF_THROTTLE: rdata_d = {16'h0000, thr_q};
                `PMGR_OFF_PLANE:    rdata_d = {28'h0000000, plane_q};
                `PMGR_OFF_STATUS:   rdata_d = {26'h0000000, stat_q};
                `PMGR_OFF_IRQ_EN:   rdata_d = {26'h0000000, irqen_q};
                `PMGR_OFF_STATE:    rdata_d = {27'h0000000, active[4], active[3],
                                               clkstop_q, pstate_q};
                default:            rdata_d = '0;
            endcase
        end
    end

    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            en_q      <= 1'b0;
            pstate_q  <= pmgr_pkg::PS_ON;
            tval_q[0] <= `PMGR_RST_DOZE_T;
            tval_q[1] <= `PMGR_RST_STBY_T;
            tval_q[2] <= `PMGR_RST_SUSPEND_THROTTLE_OUT_T;
            tval_q[3] <= `PMGR_RST_HK_T;
            tval_q[4] <= `PMGR_RST_PERIPH_T;
            thr_q     <= `PMGR_RST_THROTTLE;
            plane_q   <= '0;
            stat_q    <= '0;
            irqen_q   <= '0;
            irq_q     <= 1'b0;
            rdata_q   <= '0;
            ready_q   <= 1'b0;
            err_q     <= 1'b0;
        end else begin
            en_q      <= en_d;
            pstate_q  <= pstate_d;
            tval_q    <= tval_d;
            thr_q     <= thr_d;
            plane_q   <= plane_d;
            stat_q    <= stat_d;
            irqen_q   <= irqen_d;
            irq_q     <= irq_d;
            rdata_q   <= rdata_d;
            ready_q   <= ready_d;
            err_q     <= err_d;
        end
    end

    // ------------------------------------------------------------------
    // Suspend sequence
    // ------------------------------------------------------------------
    always_comb begin
        seq_d     = seq_q;
        stopreq_d = stopreq_q;
        clkstop_d = clkstop_q;
        unique case (seq_q)
            pmgr_pkg::SEQ_RUN: begin
                if (pstate_q == pmgr_pkg::PS_SUSPEND_THROTTLE_OUT) begin
                    seq_d     = pmgr_pkg::SEQ_DRAIN;
                    stopreq_d = 1'b1;
                end
            end
            pmgr_pkg::SEQ_DRAIN: begin
                if (pstate_q != pmgr_pkg::PS_SUSPEND_THROTTLE_OUT) begin
                    seq_d     = pmgr_pkg::SEQ_RUN;
                    stopreq_d = 1'b0;
                end else if (core_idle_in) begin
                    seq_d     = pmgr_pkg::SEQ_STOPPED;
                    clkstop_d = 1'b1;
                end
            end
            pmgr_pkg::SEQ_STOPPED: begin
                if (act.sys) begin
                    seq_d     = pmgr_pkg::SEQ_RUN;
                    stopreq_d = 1'b0;
                    clkstop_d = 1'b0;
                end
            end
            default: begin
                seq_d     = pmgr_pkg::SEQ_RUN;
                stopreq_d = 1'b0;
                clkstop_d = 1'b0;
            end
        endcase
        hksvc_d = active[3] && hk_window;
    end

    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            seq_q     <= pmgr_pkg::SEQ_RUN;
            stopreq_q <= 1'b0;
            clkstop_q <= 1'b0;
            hksvc_q   <= 1'b0;
        end else begin
            seq_q     <= seq_d;
            stopreq_q <= stopreq_d;
            clkstop_q <= clkstop_d;
            hksvc_q   <= hksvc_d;
        end
    end

    // ------------------------------------------------------------------
    // Throttle modulation, one duty field per power state
    // ------------------------------------------------------------------
    assign duty = thr_q[{pstate_q, 2'b00} +: 4];

    pmgr_throttle #(
        .W            (4)
    ) u_throttle (
        .clk_in       (clk_in),
        .reset_n_in   (reset_n_in),
        .duty_in      (duty),
        .throttle_out (throttle)
    );

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign prdata_out                = rdata_q;
    assign pready_out                = ready_q;
    assign pslverr_out               = err_q;
    assign core_stop_req_out         = stopreq_q;
    assign clock_stop_out            = clkstop_q;
    assign system_management_irq_out = irq_q;
    assign suspend_throttle_out      = throttle;
    assign power_plane_off_out       = plane_q;
    assign hk_service_out            = hksvc_q;
    assign power_state_out           = pstate_q;

endmodule

// ==== src/pmgr_cfg.svh ====
// Constants of the power manager: offsets, fields, reset values, timing
`ifndef PMGR_CFG_SVH
`define PMGR_CFG_SVH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define PMGR_OFF_CTRL      8'h00
`define PMGR_OFF_DOZE_T    8'h04
`define PMGR_OFF_STBY_T    8'h08
`define PMGR_OFF_SUSPEND_THROTTLE_OUT_T    8'h0c
`define PMGR_OFF_HK_T      8'h10
`define PMGR_OFF_PERIPH_T  8'h14
`define PMGR_OFF_THROTTLE  8'h18
`define PMGR_OFF_PLANE     8'h1c
`define PMGR_OFF_STATUS    8'h20
`define PMGR_OFF_CLEAR     8'h24
`define PMGR_OFF_IRQ_EN    8'h28
`define PMGR_OFF_STATE     8'h2c

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define PMGR_CTRL_EN_BIT   0
`define PMGR_CTRL_ST_LSB   1
`define PMGR_CTRL_ST_MSB   2
`define PMGR_EV_DOZE       0
`define PMGR_EV_STBY       1
`define PMGR_EV_SUSPEND_THROTTLE_OUT       2
`define PMGR_EV_WAKE       3
`define PMGR_EV_PERIPH     4
`define PMGR_EV_HK         5
`define PMGR_EV_W          6
`define PMGR_PLANE_W       4

// ----------------------------------------------------------------------
// Reset values, timers in prescaler ticks
// ----------------------------------------------------------------------
`define PMGR_RST_DOZE_T    16'h000a
`define PMGR_RST_STBY_T    16'h0064
`define PMGR_RST_SUSPEND_THROTTLE_OUT_T    16'h03e8
`define PMGR_RST_HK_T      16'h0005
`define PMGR_RST_PERIPH_T  16'h0064
`define PMGR_RST_THROTTLE  16'h0000

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define PMGR_CLK_HZ        10000000
`define PMGR_TICK_US       1000
`define PMGR_TICK_CYCLES   ((`PMGR_CLK_HZ / 1000000) * `PMGR_TICK_US)

`endif

// ==== src/pmgr_pkg.sv ====
// Types shared by the power manager files
package pmgr_pkg;

    // ------------------------------------------------------------------
    // Power states and suspend sequence
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        PS_ON,
        PS_DOZE,
        PS_STBY,
        PS_SUSPEND_THROTTLE_OUT
    } pmgr_pstate_t;

    typedef enum logic [1:0] {
        SEQ_RUN,
        SEQ_DRAIN,
        SEQ_STOPPED
    } pmgr_seq_t;

    // ------------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------------
    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [7:0]  paddr;
        logic [31:0] pwdata;
    } pmgr_apb_req_t;

    typedef struct packed {
        logic sys;
        logic hk;
        logic periph;
    } pmgr_act_t;

endpackage

// ==== src/pmgr_timer.sv ====
// Reloadable inactivity down-counter with expiry pulse
module pmgr_timer #(
    parameter int W = 16
) (
    // Clock and reset
    input  wire logic         clk_in,
    input  wire logic         reset_n_in,
    // Control
    input  wire logic         tick_in,
    input  wire logic         reload_in,
    input  wire logic [W-1:0] value_in,
    // Status
    output logic              expire_out,
    output logic              active_out
);

    logic [W-1:0] cnt_q;
    logic [W-1:0] cnt_d;
    logic         exp_q;
    logic         exp_d;

    // ------------------------------------------------------------------
    // Count down
    // ------------------------------------------------------------------
    always_comb begin
        cnt_d = cnt_q;
        exp_d = 1'b0;
        if (reload_in) begin
            cnt_d = value_in;
        end else if (tick_in && (cnt_q != '0)) begin
            cnt_d = cnt_q - W'(1);
            exp_d = (cnt_q == W'(1));
        end
    end

    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            cnt_q <= '0;
            exp_q <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            exp_q <= exp_d;
        end
    end

    assign expire_out = exp_q;
    assign active_out = (cnt_q != '0);

endmodule

// ==== src/pmgr_throttle.sv ====
// Duty-cycle modulator for the suspend throttle output
module pmgr_throttle #(
    parameter int W = 4
) (
    // Clock and reset
    input  wire logic         clk_in,
    input  wire logic         reset_n_in,
    // Duty in slots of a 2**W period
    input  wire logic [W-1:0] duty_in,
    // Modulated output
    output logic              throttle_out
);

    logic [W-1:0] slot_q;
    logic [W-1:0] slot_d;
    logic         out_q;
    logic         out_d;

    // ------------------------------------------------------------------
    // Slot counter and compare
    // ------------------------------------------------------------------
    always_comb begin
        slot_d = slot_q + W'(1);
        out_d  = (slot_q < duty_in);
    end

    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            slot_q <= '0;
            out_q  <= 1'b0;
        end else begin
            slot_q <= slot_d;
            out_q  <= out_d;
        end
    end

    assign throttle_out = out_q;

endmodule

// ==== test/pmgr_asserts.sv ====
// Port checker of the power manager
module pmgr_asserts (
    // Clock and reset
    input wire logic       clk_in,
    input wire logic       reset_n_in,
    // Bus handshake
    input wire logic       psel_in,
    input wire logic       penable_in,
    input wire logic       pwrite_in,
    input wire logic       pready_out,
    input wire logic       pslverr_out,
    // Core and power side
    input wire logic       sys_activity_in,
    input wire logic       core_idle_in,
    input wire logic       core_stop_req_out,
    input wire logic       clock_stop_out,
    input wire logic       hk_service_out,
    input wire logic [3:0] power_plane_off_out,
    input wire logic [1:0] power_state_out
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!reset_n_in);

    apb_wait_state_a: assert property (psel_in && penable_in && !pready_out |=>
        pready_out ##1 !pready_out) else $error("bus answer not one wait state");
    slverr_pulse_a: assert property (pslverr_out |-> pready_out)
        else $error("error without ready");
    drain_first_a: assert property ($rose(clock_stop_out) |->
        core_stop_req_out && $past(core_idle_in)) else $error("clock stopped before drain");
    drain_stop_a: assert property (core_stop_req_out && core_idle_in && !clock_stop_out
        && !sys_activity_in && power_state_out == 2'h3 |=> clock_stop_out)
        else $error("clock not stopped after drain");
    stop_in_suspend_throttle_out_a: assert property (clock_stop_out |->
        power_state_out == 2'h3 && core_stop_req_out) else $error("clock stop outside suspend");
    wake_now_a: assert property (clock_stop_out && sys_activity_in |=>
        !clock_stop_out && !core_stop_req_out && power_state_out == 2'h0)
        else $error("no wake on activity");
    hk_window_a: assert property (hk_service_out |->
        power_state_out inside {2'h1, 2'h2} || $past(power_state_out) inside {2'h1, 2'h2})
        else $error("house-keeping outside doze or standby");
    plane_by_write_a: assert property ($changed(power_plane_off_out) |->
        pready_out && pwrite_in) else $error("plane changed without write");

    cover property ($rose(clock_stop_out));
    cover property (pslverr_out);
    cover property ($rose(hk_service_out));
endmodule

bind pmgr_top pmgr_asserts u_chk (.clk_in, .reset_n_in, .psel_in, .penable_in, .pwrite_in,
    .pready_out, .pslverr_out, .sys_activity_in, .core_idle_in, .core_stop_req_out,
    .clock_stop_out, .hk_service_out, .power_plane_off_out, .power_state_out);

// ==== test/pmgr_core_model.sv ====
// Core model: drains its work before reporting idle
module pmgr_core_model (
    // Clock and reset
    input  wire logic       clk_in,
    input  wire logic       reset_n_in,
    // Stop handshake
    input  wire logic       stop_req_in,
    input  wire logic [3:0] drain_in,
    output logic            idle_out
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [3:0] left_q;
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            left_q   <= 4'h0;
            idle_out <= 1'b0;
        end else if (!stop_req_in) begin
            left_q   <= drain_in;  // Reload the drain count
            idle_out <= 1'b0;
        end else if (left_q != 4'h0) begin
            left_q <= left_q - 4'h1;  // Finish pending work
        end else begin
            idle_out <= 1'b1;  // Drained
        end
    end
endmodule

// ==== test/pmgr_top_tb_top.sv ====
// Self-checking bench of the power manager
module pmgr_top_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk_in, reset_n_in, psel_in, penable_in, pwrite_in, pready_out, pslverr_out;
    logic        sys_activity_in, hk_activity_in, periph_activity_in, core_idle_in;
    logic        core_stop_req_out, clock_stop_out, system_management_irq_out;
    logic        suspend_throttle_out, hk_service_out, rerr;
    logic [7:0]  paddr_in;
    logic [31:0] pwdata_in, prdata_out, rdat;
    logic [3:0]  power_plane_off_out, drain;
    logic [1:0]  power_state_out;
    int          n_errors, checked, i, k;
    localparam logic [40:0] ROWS [14] = '{{1'b0, 8'h00, 32'h0}, {1'b0, 8'h04, 32'ha},
        {1'b0, 8'h08, 32'h64}, {1'b0, 8'h0c, 32'h3e8}, {1'b0, 8'h10, 32'h5},
        {1'b0, 8'h14, 32'h64}, {1'b0, 8'h18, 32'h0}, {1'b0, 8'h1c, 32'h0},
        {1'b0, 8'h20, 32'h0}, {1'b0, 8'h24, 32'h0}, {1'b0, 8'h28, 32'h0},
        {1'b1, 8'h30, 32'h0}, {1'b1, 8'h02, 32'h0}, {1'b0, 8'h2c, 32'h10}};

    pmgr_top #(.TICK_CYCLES(4)) u_dut (.clk_in, .reset_n_in, .psel_in, .penable_in,
        .pwrite_in, .paddr_in, .pwdata_in, .prdata_out, .pready_out, .pslverr_out,
        .sys_activity_in, .hk_activity_in, .periph_activity_in, .core_idle_in,
        .core_stop_req_out, .clock_stop_out, .system_management_irq_out,
        .suspend_throttle_out, .power_plane_off_out, .hk_service_out, .power_state_out);
    pmgr_core_model u_core (.clk_in, .reset_n_in, .stop_req_in(core_stop_req_out),
        .drain_in(drain), .idle_out(core_idle_in));

    always #50 clk_in = ~clk_in;

    // ------------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------------
    task chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task chk1(input logic got, input logic exp);
        chk({31'h0, got}, {31'h0, exp});
    endtask
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_in);
        psel_in <= 1'b1;
        pwrite_in <= w;
        paddr_in <= a;
        pwdata_in <= d;
        @(posedge clk_in);
        penable_in <= 1'b1;
        do begin
            @(posedge clk_in);
        end while (pready_out !== 1'b1);
        rdat = prdata_out;
        rerr = pslverr_out;
        psel_in <= 1'b0;
        penable_in <= 1'b0;
    endtask
    task finish_test;
        $display("errors %0d checks %0d", n_errors, checked);
        if (n_errors == 0 && checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // ------------------------------------------------------------------
    // Sequence
    // ------------------------------------------------------------------
    initial begin
        {clk_in, reset_n_in, psel_in, penable_in, pwrite_in, paddr_in, pwdata_in} = '0;
        {sys_activity_in, hk_activity_in, periph_activity_in} = '0;
        drain = 4'h6;
        repeat (16) @(posedge clk_in);
        reset_n_in <= 1'b1;
        for (i = 0; i < 14; i++) begin
            apb(1'b0, ROWS[i][39:32], 32'h0);
            chk1(rerr, ROWS[i][40]);
            chk(rdat, ROWS[i][31:0]);
        end
        sys_activity_in <= 1'b1;
        apb(1'b1, 8'h04, 32'h2);
        apb(1'b1, 8'h08, 32'h8);
        apb(1'b1, 8'h28, 32'h9);
        apb(1'b1, 8'h14, 32'h14);
        apb(1'b1, 8'h00, 32'h1);
        repeat (40) @(posedge clk_in);
        apb(1'b0, 8'h20, 32'h0);
        chk(rdat, 32'h0);
        sys_activity_in <= 1'b0;
        for (k = 0; k < 40 && system_management_irq_out !== 1'b1; k++) @(posedge clk_in);
        chk1(system_management_irq_out, 1'b1);
        apb(1'b0, 8'h20, 32'h0);
        chk(rdat, 32'h1);
        apb(1'b1, 8'h24, 32'h1);
        repeat (40) @(posedge clk_in);
        apb(1'b0, 8'h20, 32'h0);
        chk(rdat & 32'h13, 32'h12);
        chk1(system_management_irq_out, 1'b0);
        apb(1'b1, 8'h18, 32'h8);
        k = 0;
        repeat (16) begin
            @(posedge clk_in);
            k += int'(suspend_throttle_out);
        end
        chk(32'(k), 32'h8);
        apb(1'b1, 8'h1c, 32'ha);
        chk({28'h0, power_plane_off_out}, 32'ha);
        apb(1'b1, 8'h00, 32'h3);
        hk_activity_in <= 1'b1;
        @(posedge clk_in);
        hk_activity_in <= 1'b0;
        repeat (3) @(posedge clk_in);
        chk1(hk_service_out, 1'b1);
        chk({30'h0, power_state_out}, 32'h1);
        apb(1'b1, 8'h24, 32'h3f);
        apb(1'b1, 8'h00, 32'h7);
        for (k = 0; k < 40 && clock_stop_out !== 1'b1; k++) @(posedge clk_in);
        chk1(core_idle_in, 1'b1);
        repeat (5) @(posedge clk_in);
        chk1(clock_stop_out, 1'b1);
        sys_activity_in <= 1'b1;
        @(posedge clk_in);
        sys_activity_in <= 1'b0;
        repeat (3) @(posedge clk_in);
        chk({clock_stop_out, core_stop_req_out, power_state_out}, 32'h0);
        chk1(system_management_irq_out, 1'b1);
        reset_n_in <= 1'b0;
        repeat (3) @(posedge clk_in);
        chk({power_plane_off_out, power_state_out, system_management_irq_out}, 32'h0);
        reset_n_in <= 1'b1;
        apb(1'b0, 8'h2c, 32'h0);
        chk(rdat, 32'h10);
        finish_test();
    end

    initial begin
        repeat (20000) @(posedge clk_in);
        n_errors++;
        finish_test();
    end
endmodule
